// *** hdl/tcw_pkg.sv ***
// Shared constants and types for the tick counter and watchdog block
package tcw_pkg;
    // Register port widths
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int SEL_W = 3;
    // Register offsets
    localparam logic [2:0] OFF_CTRL = 3'h0;
    localparam logic [2:0] OFF_COUNT = 3'h1;
    localparam logic [2:0] OFF_WDCTRL = 3'h2;
    localparam logic [2:0] OFF_INSTR = 3'h3;
    localparam logic [2:0] OFF_STATUS = 3'h4;
    localparam logic [2:0] OFF_MASK = 3'h5;
    localparam logic [2:0] OFF_STATE = 3'h6;
    // Counter control field positions
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_PSE_BIT = 3;
    localparam int CTRL_EDGE_BIT = 4;
    localparam int CTRL_SRC_BIT = 5;
    // Watchdog control field positions
    localparam int WD_SEL_LSB = 2;
    localparam int WD_PSE_BIT = 5;
    localparam int WD_EN_BIT = 7;
    // Instruction strobe bits
    localparam int INSTR_CLR_BIT = 0;
    localparam int INSTR_SLEEP_BIT = 1;
    // Status and mask bits
    localparam int ST_OVF_BIT = 0;
    localparam int ST_WDOG_BIT = 1;
    // Reset values and masks
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'h3F;
    localparam logic [7:0] WDCTRL_RST = 8'h80;
    localparam logic [7:0] WDCTRL_WMASK = 8'hBC;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [1:0] EVT_W_MASK = 2'h3;
    // Timing: watchdog period with the prescaler bypassed
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned WDOG_TIMEOUT_NS = 18000000;
    localparam int unsigned WDOG_STEPS = 256;
    localparam int unsigned WDOG_TIMEOUT_CYCLES = WDOG_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int unsigned RC_TICK_CYCLES_DFLT = WDOG_TIMEOUT_CYCLES / WDOG_STEPS;
    // Power state of the core
    typedef enum logic [0:0] {
        TCW_RUN = 1'h0,
        TCW_SLEEP = 1'h1
    } tcw_pwr_t;
endpackage

// *** hdl/tcw_prescale_if.sv ***
// Bundle between the top and one prescaler instance
`timescale 1ns/10ps
interface tcw_prescale_if;
    import tcw_pkg::*;
    logic tick_in; // Raw count event
    logic clear; // Zero the prescaler count
    logic en; // Prescaler in use, else bypass
    logic [SEL_W-1:0] sel; // Ratio code, 0 gives 1:2
    logic tick_out; // Divided event
    logic [7:0] count; // Current prescaler count
    modport div (input tick_in, input clear, input en, input sel, output tick_out, output count);
    modport ctl (output tick_in, output clear, output en, output sel, input tick_out, input count);
endinterface

// *** hdl/tcw_prescaler.sv ***
// Eight-bit prescaler with ratio 1:2 up to 1:256 or bypass
`timescale 1ns/10ps
module tcw_prescaler
    import tcw_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    tcw_prescale_if.div pre
);
    logic [7:0] count_reg; // Events seen since last output
    logic [8:0] ratio; // Selected division ratio
    logic [7:0] limit; // Last count before output
    logic hit; // Ratio completed this cycle

    // Ratio doubles per code step
    assign ratio = 9'h002 << pre.sel;
    assign limit = 8'(ratio - 9'h001);
    assign hit = pre.tick_in && (count_reg == limit);
    // A clear swallows a coinciding event
    assign pre.tick_out = !pre.clear && (pre.en ? hit : pre.tick_in);
    assign pre.count = count_reg;

    // Prescaler count, held at zero while bypassed
    always_ff @(posedge ref_clk) begin
        if (!nrst || pre.clear || !pre.en) begin
            count_reg <= COUNT_RST;
        end else if (hit) begin
            count_reg <= COUNT_RST;
        end else if (pre.tick_in) begin
            count_reg <= 8'(count_reg + 8'h01);
        end
    end
endmodule

// *** hdl/tcw_top.sv ***
// Tick counter and watchdog with their prescalers and register port
`timescale 1ns/10ps
module tcw_top
    import tcw_pkg::*;
#(
    parameter int unsigned RC_TICK_CYCLES = RC_TICK_CYCLES_DFLT
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic tick_count_pin,
    output logic irq,
    output logic watchdog_reset,
    output logic sleep_active
);
    // Register state
    logic [7:0] counter_control_reg; // Timer source, edge and prescale
    logic [7:0] tick_counter_reg; // Timer value
    logic [7:0] watchdog_control_reg; // Watchdog enable and prescale
    logic [7:0] wdog_count_reg; // Watchdog count
    logic [1:0] status_reg; // Sticky event flags
    logic [1:0] mask_reg; // Interrupt enables
    logic [7:0] rdata_reg; // Read data, valid one cycle
    tcw_pwr_t pwr_reg; // Run or sleep
    tcw_pwr_t pwr_next;

    // Pin synchroniser and edge detect
    logic pin_sync1_reg; // Meta stage, read only by stage two
    logic pin_sync2_reg;
    logic pin_prev_reg;
    logic pin_edge;

    // Free running RC tick divider
    logic [31:0] rc_div_reg;
    logic rc_tick;

    // Decoded strobes and fields
    logic wr_ctrl;
    logic wr_count;
    logic wr_wdctrl;
    logic wr_status;
    logic wr_mask;
    logic clr_pulse; // Watchdog clear instruction
    logic sleep_pulse; // Sleep instruction
    logic soft_rst; // Device reset from watchdog
    logic wdog_clr;
    logic tick_src_pin;
    logic tick_edge_fall;
    logic wd_en;
    logic wdog_fire_reg; // One-cycle device reset
    logic ovf_evt;
    logic wdog_evt;
    logic chk_live_reg; // Checks armed one edge after reset leaves
    logic [1:0] evt;

    tcw_prescale_if tick_pre_if();
    tcw_prescale_if wd_pre_if();

    // Register port decode
    assign wr_ctrl = reg_wr && (reg_addr == OFF_CTRL);
    assign wr_count = reg_wr && (reg_addr == OFF_COUNT);
    assign wr_wdctrl = reg_wr && (reg_addr == OFF_WDCTRL);
    assign wr_status = reg_wr && (reg_addr == OFF_STATUS);
    assign wr_mask = reg_wr && (reg_addr == OFF_MASK);
    assign clr_pulse = reg_wr && (reg_addr == OFF_INSTR) && reg_wdata[INSTR_CLR_BIT];
    assign sleep_pulse = reg_wr && (reg_addr == OFF_INSTR) && reg_wdata[INSTR_SLEEP_BIT];
    assign soft_rst = wdog_fire_reg;

    // Field aliases
    assign tick_src_pin = counter_control_reg[CTRL_SRC_BIT];
    assign tick_edge_fall = counter_control_reg[CTRL_EDGE_BIT];
    assign wd_en = watchdog_control_reg[WD_EN_BIT];

    // Counter control; watchdog reset restores defaults
    always_ff @(posedge ref_clk) begin
        if (!nrst || soft_rst) begin
            counter_control_reg <= CTRL_RST;
        end else if (wr_ctrl) begin
            counter_control_reg <= reg_wdata & CTRL_WMASK;
        end
    end

    // Watchdog control, unused bits stay zero
    always_ff @(posedge ref_clk) begin
        if (!nrst || soft_rst) begin
            watchdog_control_reg <= WDCTRL_RST;
        end else if (wr_wdctrl) begin
            watchdog_control_reg <= reg_wdata & WDCTRL_WMASK;
        end
    end

    // Pin passes two flops; sources must hold each level over a clock
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pin_sync1_reg <= 1'h0;
            pin_sync2_reg <= 1'h0;
            pin_prev_reg <= 1'h0;
        end else begin
            pin_sync1_reg <= tick_count_pin;
            pin_sync2_reg <= pin_sync1_reg;
            pin_prev_reg <= pin_sync2_reg;
        end
    end

    // Selected edge of the synchronised pin
    assign pin_edge = tick_edge_fall ? (pin_prev_reg && !pin_sync2_reg)
                                     : (!pin_prev_reg && pin_sync2_reg);

    // Timer prescaler hookup; the timer stops in sleep
    assign tick_pre_if.tick_in = (pwr_reg == TCW_RUN) && (tick_src_pin ? pin_edge : 1'h1);
    assign tick_pre_if.clear = wr_count || soft_rst;
    assign tick_pre_if.en = counter_control_reg[CTRL_PSE_BIT];
    assign tick_pre_if.sel = counter_control_reg[CTRL_SEL_LSB +: SEL_W];

    // Dedicated timer prescaler
    tcw_prescaler u_tick_pre (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pre(tick_pre_if)
    );

    // Tick counter; a write beats a coinciding step
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            tick_counter_reg <= COUNT_RST;
        end else if (wr_count) begin
            tick_counter_reg <= reg_wdata;
        end else if (tick_pre_if.tick_out) begin
            tick_counter_reg <= 8'(tick_counter_reg + 8'h01);
        end
    end

    assign ovf_evt = tick_pre_if.tick_out && !wr_count && (tick_counter_reg == COUNT_MAX);

    // RC tick stands in for the on-chip oscillator; never stopped
    assign rc_tick = (rc_div_reg == 32'(RC_TICK_CYCLES - 1));
    always_ff @(posedge ref_clk) begin
        if (!nrst || rc_tick) begin
            rc_div_reg <= 32'h0000_0000;
        end else begin
            rc_div_reg <= rc_div_reg + 32'h0000_0001;
        end
    end

    // Watchdog prescaler hookup
    assign wdog_clr = clr_pulse || sleep_pulse || soft_rst;
    assign wd_pre_if.tick_in = rc_tick && wd_en;
    assign wd_pre_if.clear = wdog_clr;
    assign wd_pre_if.en = watchdog_control_reg[WD_PSE_BIT];
    assign wd_pre_if.sel = watchdog_control_reg[WD_SEL_LSB +: SEL_W];

    // Dedicated watchdog prescaler
    tcw_prescaler u_wd_pre (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pre(wd_pre_if)
    );

    // Watchdog count: 256 bypassed RC ticks make the time-out
    always_ff @(posedge ref_clk) begin
        if (!nrst || wdog_clr) begin
            wdog_count_reg <= COUNT_RST;
        end else if (wd_pre_if.tick_out) begin
            wdog_count_reg <= 8'(wdog_count_reg + 8'h01);
        end
    end

    assign wdog_evt = wd_pre_if.tick_out && (wdog_count_reg == COUNT_MAX);

    // Time-out fires a one-cycle device reset, asleep or not
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wdog_fire_reg <= 1'h0;
        end else begin
            wdog_fire_reg <= wdog_evt;
        end
    end
    assign watchdog_reset = wdog_fire_reg;

    // Power state; only a reset wakes the core
    always_comb begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            TCW_RUN: begin
                if (sleep_pulse) begin
                    pwr_next = TCW_SLEEP;
                end
            end
            TCW_SLEEP: begin
                pwr_next = TCW_SLEEP;
            end
            default: begin
                pwr_next = TCW_RUN;
            end
        endcase
    end

    // Watchdog reset also wakes from sleep
    always_ff @(posedge ref_clk) begin
        if (!nrst || soft_rst) begin
            pwr_reg <= TCW_RUN;
        end else begin
            pwr_reg <= pwr_next;
        end
    end
    assign sleep_active = (pwr_reg == TCW_SLEEP);

    // Sticky flags; a new event wins over a write-one clear
    assign evt = {wdog_evt, ovf_evt};
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            status_reg <= 2'h0;
        end else if (wr_status) begin
            status_reg <= (status_reg & ~reg_wdata[1:0]) | evt;
        end else begin
            status_reg <= status_reg | evt;
        end
    end

    // Mask survives watchdog reset so the cause can be served
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            mask_reg <= MASK_RST[1:0];
        end else if (wr_mask) begin
            mask_reg <= reg_wdata[1:0] & EVT_W_MASK;
        end
    end

    assign irq = |(status_reg & mask_reg);

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk) begin
        if (!nrst || !reg_rd) begin
            rdata_reg <= 8'h00;
        end else begin
            case (reg_addr)
                OFF_CTRL: rdata_reg <= counter_control_reg;
                OFF_COUNT: rdata_reg <= tick_counter_reg;
                OFF_WDCTRL: rdata_reg <= watchdog_control_reg;
                OFF_STATUS: rdata_reg <= {6'h00, status_reg};
                OFF_MASK: rdata_reg <= {6'h00, mask_reg};
                OFF_STATE: rdata_reg <= {7'h00, sleep_active};
                default: rdata_reg <= 8'h00; // Unmapped and instruction slot
            endcase
        end
    end
    assign reg_rdata = rdata_reg;

    // Reset is synchronous, so the edge that sees nrst rise still holds
    // reset state; $past checks would compare against it without this flop
    always_ff @(posedge ref_clk) begin
        chk_live_reg <= nrst;
    end

    // Checks on the running design
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst || !chk_live_reg);

    // Plain internal counting with no interference
    sequence s_int_plain;
        (pwr_reg == TCW_RUN) && !tick_src_pin && !tick_pre_if.en && !wr_count && !soft_rst;
    endsequence

    // Synchronised rising pin edge in pin mode
    sequence s_pin_rise;
        tick_src_pin && !tick_edge_fall && !pin_prev_reg && pin_sync2_reg;
    endsequence

    // Watchdog count at its end with a step pending
    sequence s_wdog_end;
        wd_pre_if.tick_out && (wdog_count_reg == COUNT_MAX);
    endsequence

    a_count_write_load: assert property (
        wr_count |=> (tick_counter_reg == $past(reg_wdata)) && (tick_pre_if.count == 8'h00))
        else $error("tick counter write did not load or clear prescaler");

    a_wdog_instr_clear: assert property (
        (clr_pulse || sleep_pulse) |=> (wdog_count_reg == 8'h00) && (wd_pre_if.count == 8'h00))
        else $error("watchdog not cleared by clear or sleep");

    a_tick_internal_rate: assert property (
        s_int_plain |=> tick_counter_reg == 8'($past(tick_counter_reg) + 8'h01))
        else $error("internal clock did not step tick counter by one");

    a_tick_pin_edge: assert property (
        s_pin_rise ##0 ((pwr_reg == TCW_RUN) && !tick_pre_if.en && !wr_count)
        |=> tick_counter_reg == 8'($past(tick_counter_reg) + 8'h01))
        else $error("pin edge did not step tick counter");

    a_tick_pin_idle: assert property (
        (tick_src_pin && !pin_edge && !wr_count) |=> $stable(tick_counter_reg))
        else $error("tick counter moved without a pin edge");

    a_tick_wrap: assert property (
        (tick_pre_if.tick_out && !wr_count && (tick_counter_reg == COUNT_MAX))
        |=> (tick_counter_reg == 8'h00) && status_reg[ST_OVF_BIT])
        else $error("tick counter did not wrap to zero");

    a_tick_prescaled: assert property (
        (tick_pre_if.tick_out && tick_pre_if.en) |=> !tick_pre_if.tick_out)
        else $error("prescaled timer stepped on consecutive cycles");

    a_wdog_fire_reset: assert property (
        s_wdog_end |=> watchdog_reset ##1
        (!watchdog_reset && (watchdog_control_reg == WDCTRL_RST) && (pwr_reg == TCW_RUN)))
        else $error("watchdog time-out did not reset the device");

    a_wdog_off_hold: assert property (
        (!wd_en && !wdog_clr) |=> $stable(wdog_count_reg))
        else $error("disabled watchdog kept counting");

    a_wdog_sleep_runs: assert property (
        (sleep_active && wd_en && !wd_pre_if.en && rc_tick && !wdog_clr
        && (wdog_count_reg != COUNT_MAX)) |=> wdog_count_reg == 8'($past(wdog_count_reg) + 8'h01))
        else $error("watchdog stalled during sleep");

    a_wdctrl_unused_zero: assert property (
        (watchdog_control_reg[6] == 1'h0) && (watchdog_control_reg[1:0] == 2'h0))
        else $error("unused watchdog control bits set");
endmodule

// *** tb/tcw_pin_source.sv ***
// Model of the outside source that drives the tick count pin
`timescale 1ns/10ps
module tcw_pin_source (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic go, // Start a burst of toggles
    input wire logic [7:0] toggles, // Level changes to make
    input wire logic [3:0] hold, // Cycles each level stands
    output logic pin, // Count pin level
    output logic busy // Burst in progress
);
    logic [7:0] left_reg; // Toggles still to make
    logic [3:0] cnt_reg; // Cycles left at this level
    logic [3:0] hold_min; // Hold with a floor of two
    // Shorter levels could slip past the sampler, so never below two
    assign hold_min = (hold < 4'h2) ? 4'h2 : hold;
    // Burst sequencer, the pin moves only after a full hold
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pin <= 1'b0;
            busy <= 1'b0;
            left_reg <= 8'h00;
            cnt_reg <= 4'h0;
        end else if (go && !busy) begin
            busy <= 1'b1;
            left_reg <= toggles;
            cnt_reg <= hold_min;
        end else if (busy) begin
            if (left_reg == 8'h00) begin
                busy <= 1'b0; // Burst done, pin keeps its level
            end else if (cnt_reg <= 4'h1) begin
                pin <= ~pin;
                left_reg <= left_reg - 8'h01;
                cnt_reg <= hold_min;
            end else begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the tick counter and watchdog block
`timescale 1ns/10ps
module testbench;
    import tcw_pkg::*;
    localparam int RC = 2; // Short RC tick keeps time-outs brief
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 3'h0;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic pin; // Count pin from the source model
    logic irq;
    logic watchdog_reset;
    logic sleep_active;
    logic go = 1'b0; // Source burst start
    logic [7:0] toggles = 8'h00;
    logic [3:0] hold = 4'h2;
    logic busy;
    int errors = 0;
    int total_checks = 0;
    logic [7:0] rv; // Last read value
    logic [7:0] wd; // Watchdog control under test

    tcw_top #(.RC_TICK_CYCLES(RC)) u_tcw_top (.ref_clk(ref_clk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tick_count_pin(pin), .irq(irq),
        .watchdog_reset(watchdog_reset), .sleep_active(sleep_active));
    tcw_pin_source u_tcw_pin_source (.ref_clk(ref_clk), .nrst(nrst), .go(go),
        .toggles(toggles), .hold(hold), .pin(pin), .busy(busy));

    // Free running 250 MHz clock
    always #2 ref_clk = ~ref_clk;

    // Closing report, the only exit of the run
    task results();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Byte comparison
    task chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Single bit comparison
    task chk1(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask
    // Every bus task starts and ends just after a rising edge
    task wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Read data stands only in the cycle after the strobe
    task rdc(input logic [2:0] a, input logic [7:0] exp, input string what);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        rv = reg_rdata;
        @(posedge ref_clk);
        chk8(what, exp, rv);
    endtask
    task wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Waits for the time-out pulse, bounded, and checks its moment
    task wd_wait(input int r);
        int n;
        n = 0;
        while (watchdog_reset !== 1'b1 && n < 256 * r * RC + 8) begin
            @(negedge ref_clk);
            n++;
        end
        chk1("time-out window", 1'b1, (n >= 255 * r * RC - 2) && (n <= 256 * r * RC + 4));
        if (watchdog_reset !== 1'b1) results();
        @(posedge ref_clk);
        wait_cyc(2); // Let the internal reset land
    endtask
    // No time-out pulse may appear for n cycles
    task no_wd(input int n);
        int hits;
        hits = 0;
        repeat (n) begin
            @(negedge ref_clk);
            if (watchdog_reset === 1'b1) hits++;
        end
        chk1("unexpected time-out", 1'b0, hits != 0);
        @(posedge ref_clk);
    endtask
    // One burst of pin toggles, bounded wait for its end
    task pulse(input logic [7:0] t, input logic [3:0] h);
        int n;
        toggles <= t;
        hold <= h;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (busy === 1'b1 && n < 200);
        if (n >= 200) begin
            errors++;
            results();
        end
        @(posedge ref_clk);
        wait_cyc(6); // Synchroniser and edge detect latency
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        wait_cyc(2);
        // Reset values and unmapped places
        rdc(OFF_CTRL, CTRL_RST, "counter control reset");
        rdc(OFF_WDCTRL, 8'h80, "watchdog control reset");
        rdc(OFF_MASK, MASK_RST, "mask reset");
        rdc(OFF_STATE, 8'h00, "state reset");
        rdc(OFF_INSTR, 8'h00, "instruction read");
        rdc(3'h7, 8'h00, "unmapped read");
        $display("test reset values done");
        // Watchdog ratios, sleep and clear; status bit 1 unmasked
        wr(OFF_MASK, 8'h02);
        for (int i = 0; i < 9; i++) begin
            wd = (i == 0) ? 8'h80 : (8'hA0 | 8'((i - 1) << 2));
            wr(OFF_WDCTRL, wd);
            rdc(OFF_WDCTRL, wd & WDCTRL_WMASK, "watchdog control");
            if (i < 7) begin
                wr(OFF_INSTR, (i == 0) ? 8'h02 : 8'h01);
                if (i == 0) chk1("sleep entered", 1'b1, sleep_active);
                wd_wait((i == 0) ? 1 : (2 << (i - 1)));
                chk1("sleep left on time-out", 1'b0, sleep_active);
                rdc(OFF_WDCTRL, WDCTRL_RST, "watchdog control after time-out");
                chk1("irq on time-out", 1'b1, irq);
                wr(OFF_STATUS, 8'h02);
                chk1("irq after clear", 1'b0, irq);
            end
        end
        wr(OFF_MASK, 8'h00);
        $display("test watchdog ratios done");
        // Disabled watchdog stays quiet, clears hold it off
        wr(OFF_WDCTRL, 8'h00);
        no_wd(700);
        wr(OFF_WDCTRL, 8'h80);
        wr(OFF_INSTR, 8'h01);
        repeat (3) begin
            no_wd(300);
            wr(OFF_INSTR, 8'h01);
        end
        wr(OFF_WDCTRL, 8'h00);
        $display("test watchdog clear done");
        // Internal count, wrap and the overflow interrupt
        wr(OFF_CTRL, 8'h00);
        wr(OFF_STATUS, 8'h03);
        wr(OFF_COUNT, 8'hFE);
        rdc(OFF_COUNT, 8'hFF, "count after write");
        rdc(OFF_COUNT, 8'h01, "count after wrap");
        rdc(OFF_STATUS, 8'h01, "overflow status");
        chk1("irq masked", 1'b0, irq);
        wr(OFF_MASK, 8'h01);
        chk1("irq unmasked", 1'b1, irq);
        wr(OFF_STATUS, 8'h01);
        chk1("irq cleared", 1'b0, irq);
        wr(OFF_MASK, 8'h00);
        $display("test count and wrap done");
        // Timer prescaler codes, reserved bits ignored
        for (int n = 0; n < 8; n++) begin
            wr(OFF_CTRL, 8'hC8 | 8'(n));
            rdc(OFF_CTRL, 8'h08 | 8'(n), "counter control");
            wait_cyc(37); // Leave the prescaler part way
            wr(OFF_COUNT, 8'h00);
            wait_cyc(2 * (2 << n) + (1 << n) - 1);
            rdc(OFF_COUNT, 8'h02, "prescaled count");
        end
        $display("test timer prescaler done");
        // Pin source on each edge, slow and prompt source
        wr(OFF_CTRL, 8'h20);
        wr(OFF_COUNT, 8'h00);
        pulse(8'h05, 4'h2);
        rdc(OFF_COUNT, 8'h03, "rising edge count");
        wr(OFF_CTRL, 8'h30);
        wr(OFF_COUNT, 8'h00);
        pulse(8'h05, 4'h4);
        rdc(OFF_COUNT, 8'h03, "falling edge count");
        $display("test pin source done");
        results();
    end
endmodule
